// ==== rtl/cc_channel.sv ====
/*
  One capture/compare channel: input capture, compare event and output unit.
  Assumes capture inputs already synchronised and a count-updated strobe from the counter.
*/
`timescale 1ns/1ns
`default_nettype none
module cc_channel import tmr_pkg::*; (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire chan_cfg_s        cfg,
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic             cnt_new,
  input  wire logic             period_hit,
  input  wire logic [1:0]       cap_now,
  input  wire logic [1:0]       cap_prev,
  output chan_stat_s            stat
);

  logic             out_q, out_d;
  logic             irq_q;
  logic [CNT_W-1:0] cap_q;
  cap_in_e          in_sel_q;

  // ----------------------------------------------------------------
  // Input select and edge detect
  // ----------------------------------------------------------------
  // The previous level is taken through last cycle's in_sel, so a switch of source
  // is an edge: stepping from ground to supply gives a software capture
  wire logic sel_now  = (cfg.in_sel == CAP_IN_A) ? cap_now[0]  :
                        (cfg.in_sel == CAP_IN_B) ? cap_now[1]  :
                        (cfg.in_sel == CAP_IN_VCC);
  wire logic sel_prev = (in_sel_q == CAP_IN_A) ? cap_prev[0] :
                        (in_sel_q == CAP_IN_B) ? cap_prev[1] :
                        (in_sel_q == CAP_IN_VCC);
  wire logic rise     = sel_now & ~sel_prev;
  wire logic fall     = ~sel_now & sel_prev;
  wire logic cap_hit  = cfg.capture &
                        (((cfg.edge_sel == EDGE_RISE) & rise) |
                         ((cfg.edge_sel == EDGE_FALL) & fall) |
                         ((cfg.edge_sel == EDGE_BOTH) & (rise | fall)));
  wire logic cmp_hit  = ~cfg.capture & cnt_new & (cnt == cfg.compare);

  // ----------------------------------------------------------------
  // Output unit
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.out_mode)
      OUT_VALUE:   out_d = cfg.out_value;
      OUT_SET:     out_d = cmp_hit ? 1'b1 : out_q;
      OUT_TOG_RST: out_d = cmp_hit ? ~out_q : (period_hit ? 1'b0 : out_q);
      OUT_SET_RST: out_d = cmp_hit ? 1'b1 : (period_hit ? 1'b0 : out_q);
      OUT_TOG:     out_d = cmp_hit ? ~out_q : out_q;
      OUT_RST:     out_d = cmp_hit ? 1'b0 : out_q;
      OUT_TOG_SET: out_d = cmp_hit ? ~out_q : (period_hit ? 1'b1 : out_q);
      OUT_RST_SET: out_d = cmp_hit ? 1'b0 : (period_hit ? 1'b1 : out_q);
      default:     out_d = out_q;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      out_q <= 1'b0;
      irq_q <= 1'b0;
      cap_q    <= CNT_RST;
      in_sel_q <= CAP_IN_A;
    end else begin
      in_sel_q <= cfg.in_sel;
      out_q <= out_d;
      irq_q <= cap_hit | cmp_hit;
      if (cap_hit) begin
        cap_q <= cnt;
      end
    end
  end

  assign stat = '{out: out_q, irq: irq_q, capture: cap_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cmp_irq;
    @(posedge mclk) disable iff (!rst_b)
      (!cfg.capture && cnt_new && cnt == cfg.compare) |=> stat.irq;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare match gave no request");

  property p_cap_value;
    @(posedge mclk) disable iff (!rst_b)
      cap_hit |=> (stat.capture == $past(cnt)) && stat.irq;
  endproperty
  a_cap_value: assert property (p_cap_value) else $error("capture missed counter value");

  property p_set_mode;
    @(posedge mclk) disable iff (!rst_b)
      (cfg.out_mode == OUT_SET && !cfg.capture && cnt_new && cnt == cfg.compare) |=> stat.out;
  endproperty
  a_set_mode: assert property (p_set_mode) else $error("set mode did not raise output");

  c_capture: cover property (@(posedge mclk) disable iff (!rst_b) cap_hit);

endmodule // cc_channel
`default_nettype wire

// ==== rtl/general_timer.sv ====
/*
  General timer with seven capture/compare channels and the conversion-trigger selector.
  Assumes pin clocks and capture inputs are asynchronous to mclk; basic-timer
  outputs and the software start bit come from logic on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module general_timer import tmr_pkg::*; (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire count_mode_e           count_mode,
  input  wire clk_src_e              clk_sel,
  input  wire logic                  external_timer_clock,
  input  wire logic                  alternate_timer_clock,
  input  wire logic                  aux_clock,
  input  wire logic [NUM_CH-1:0]     capture_in_a,
  input  wire logic [NUM_CH-1:0]     capture_in_b,
  input  wire chan_cfg_s [NUM_CH-1:0] chan_cfg,
  input  wire logic [2:0]            conv_trigger_select,
  input  wire logic                  software_conv_start,
  input  wire logic [NUM_BT-1:0]     basic_timer_ch1_out,
  output logic [CNT_W-1:0]           counter_value,
  output chan_stat_s [NUM_CH-1:0]    chan_status,
  output logic                       overflow_irq,
  output logic                       conv_trigger
);

  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic              dir_down_q, dir_down_d;
  logic              ovf_q, ovf_d;
  logic              cnt_new_q;
  logic              trig_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Third stage only feeds edge detection, so stage one stays private
  wire logic [SYNC_W-1:0] pins = {capture_in_b, capture_in_a, aux_clock,
                                  alternate_timer_clock, external_timer_clock};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter clock select
  // ----------------------------------------------------------------
  // Pin clocks must stay below mclk / 4 to survive the synchroniser
  wire logic ext_rise = sync2_q[SYNC_EXT] & ~sync3_q[SYNC_EXT];
  wire logic alt_fall = ~sync2_q[SYNC_ALT] & sync3_q[SYNC_ALT];
  wire logic aux_rise = sync2_q[SYNC_AUX] & ~sync3_q[SYNC_AUX];
  wire logic tick_src = (clk_sel == CLK_EXT)   ? ext_rise :
                        (clk_sel == CLK_AUX)   ? aux_rise :
                        (clk_sel == CLK_SUBSYS) ? 1'b1    : alt_fall;
  wire logic tick     = tick_src & (count_mode != MODE_STOP);
  wire logic [CNT_W-1:0] period = chan_cfg[0].compare;

  // ----------------------------------------------------------------
  // Shared counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d      = cnt_q;
    dir_down_d = dir_down_q;
    ovf_d      = 1'b0;
    if (tick) begin
      case (count_mode)
        MODE_UP: begin
          if (cnt_q >= period) begin
            cnt_d = CNT_RST;
            ovf_d = 1'b1;
          end else begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
        MODE_CONT: begin
          cnt_d = cnt_q + CNT_ONE;
          ovf_d = (cnt_q == CNT_MAX);
        end
        MODE_UPDOWN: begin
          if (!dir_down_q) begin
            if (cnt_q >= period && cnt_q != CNT_RST) begin
              dir_down_d = 1'b1;
              cnt_d      = cnt_q - CNT_ONE;
            end else if (cnt_q < period) begin
              cnt_d = cnt_q + CNT_ONE;
            end
          end else begin
            if (cnt_q == CNT_RST) begin
              dir_down_d = 1'b0;
            end else begin
              cnt_d = cnt_q - CNT_ONE;
              if (cnt_q == CNT_ONE) begin
                ovf_d      = 1'b1;
                dir_down_d = 1'b0;
              end
            end
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q      <= CNT_RST;
      dir_down_q <= 1'b0;
      ovf_q      <= 1'b0;
      cnt_new_q  <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      dir_down_q <= dir_down_d;
      ovf_q      <= ovf_d;
      cnt_new_q  <= tick;
    end
  end

  assign counter_value = cnt_q;
  assign overflow_irq  = ovf_q;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  wire logic period_hit = cnt_new_q & (cnt_q == period);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      cc_channel u_ch (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .cfg        (chan_cfg[ch]),
        .cnt        (cnt_q),
        .cnt_new    (cnt_new_q),
        .period_hit (period_hit),
        .cap_now    ({sync2_q[SYNC_CAP+NUM_CH+ch], sync2_q[SYNC_CAP+ch]}),
        .cap_prev   ({sync3_q[SYNC_CAP+NUM_CH+ch], sync3_q[SYNC_CAP+ch]}),
        .stat       (chan_status[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Conversion trigger selector
  // ----------------------------------------------------------------
  wire logic ch0_out = chan_status[0].out;
  wire logic ch1_out = chan_status[1].out;
  wire logic trig_d  =
    (conv_trigger_select == TRIG_SW)      ? software_conv_start    :
    (conv_trigger_select == TRIG_BT0_CH1) ? basic_timer_ch1_out[0] :
    (conv_trigger_select == TRIG_CH0)     ? ch0_out                :
    (conv_trigger_select == TRIG_CH1)     ? ch1_out                :
    (conv_trigger_select == TRIG_BT1_CH1) ? basic_timer_ch1_out[1] :
    (conv_trigger_select == TRIG_BT2_CH1) ? basic_timer_ch1_out[2] :
    (conv_trigger_select == TRIG_BT3_CH1) ? basic_timer_ch1_out[3] :
    1'b0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  assign conv_trigger = trig_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cont_count;
    @(posedge mclk) disable iff (!rst_b)
      (count_mode == MODE_CONT && clk_sel == CLK_SUBSYS) ##1 (count_mode == MODE_CONT && clk_sel == CLK_SUBSYS)
        |-> cnt_q == $past(cnt_q) + CNT_ONE;
  endproperty
  a_cont_count: assert property (p_cont_count) else $error("counter did not step by one");

  property p_cont_ovf;
    @(posedge mclk) disable iff (!rst_b)
      (tick && count_mode == MODE_CONT && cnt_q == CNT_MAX) |=> overflow_irq && cnt_q == CNT_RST;
  endproperty
  a_cont_ovf: assert property (p_cont_ovf) else $error("no overflow request at wrap");

  property p_up_wrap;
    @(posedge mclk) disable iff (!rst_b)
      (tick && count_mode == MODE_UP && cnt_q >= period) |=> cnt_q == CNT_RST && overflow_irq;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up mode did not wrap at period");

  property p_ch0_route;
    @(posedge mclk) disable iff (!rst_b)
      conv_trigger_select == TRIG_CH0 |=> conv_trigger == $past(chan_status[0].out);
  endproperty
  a_ch0_route: assert property (p_ch0_route) else $error("source 2 not channel zero");

  property p_ch1_route;
    @(posedge mclk) disable iff (!rst_b)
      conv_trigger_select == TRIG_CH1 |=> conv_trigger == $past(chan_status[1].out);
  endproperty
  a_ch1_route: assert property (p_ch1_route) else $error("source 3 not channel one");

  property p_bt_route;
    @(posedge mclk) disable iff (!rst_b)
      (conv_trigger_select == TRIG_BT0_CH1 || conv_trigger_select == TRIG_BT3_CH1)
        |=> conv_trigger == ($past(conv_trigger_select) == TRIG_BT0_CH1 ?
                             $past(basic_timer_ch1_out[0]) : $past(basic_timer_ch1_out[3]));
  endproperty
  a_bt_route: assert property (p_bt_route) else $error("basic timer source misrouted");

  property p_sw_rsvd;
    @(posedge mclk) disable iff (!rst_b)
      (conv_trigger_select == TRIG_RSVD |=> !conv_trigger) and
      (conv_trigger_select == TRIG_SW |=> conv_trigger == $past(software_conv_start));
  endproperty
  a_sw_rsvd: assert property (p_sw_rsvd) else $error("software or reserved code wrong");

  property p_sys_tick;
    @(posedge mclk) disable iff (!rst_b)
      (clk_sel == CLK_SUBSYS && count_mode != MODE_STOP) |=> cnt_new_q;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("subsystem clock did not count");

  property p_ovf_pulse;
    @(posedge mclk) disable iff (!rst_b)
      overflow_irq |=> !overflow_irq || clk_sel == CLK_SUBSYS;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow request stuck");

  c_updown_ovf: cover property (@(posedge mclk) disable iff (!rst_b)
                                count_mode == MODE_UPDOWN && overflow_irq);
  c_ch0_trig:   cover property (@(posedge mclk) disable iff (!rst_b)
                                conv_trigger_select == TRIG_CH0 ##1 conv_trigger);
  c_ext_clk:    cover property (@(posedge mclk) disable iff (!rst_b)
                                clk_sel == CLK_EXT && tick);

endmodule // general_timer
`default_nettype wire

// ==== rtl/tmr_pkg.sv ====
/*
  Shared constants, modes and carrier structs for the general timer
  and its conversion-trigger selector.
  Assumes one clock (mclk) and that all configuration arrives on plain ports.
*/
package tmr_pkg;

  localparam int CNT_W  = 16;
  localparam int NUM_CH = 7;
  localparam int NUM_BT = 4;
  // Three clock pins plus two capture inputs per channel
  localparam int SYNC_W = 3 + 2 * NUM_CH;

  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;

  // Positions inside the synchroniser vector
  localparam int SYNC_EXT = 0;
  localparam int SYNC_ALT = 1;
  localparam int SYNC_AUX = 2;
  localparam int SYNC_CAP = 3;

  // Conversion trigger selector codes
  localparam logic [2:0] TRIG_SW      = 3'h0;
  localparam logic [2:0] TRIG_BT0_CH1 = 3'h1;
  localparam logic [2:0] TRIG_CH0     = 3'h2;
  localparam logic [2:0] TRIG_CH1     = 3'h3;
  localparam logic [2:0] TRIG_BT1_CH1 = 3'h4;
  localparam logic [2:0] TRIG_BT2_CH1 = 3'h5;
  localparam logic [2:0] TRIG_BT3_CH1 = 3'h6;
  localparam logic [2:0] TRIG_RSVD    = 3'h7;

  typedef enum logic [1:0] {CLK_EXT, CLK_AUX, CLK_SUBSYS, CLK_ALT} clk_src_e;
  typedef enum logic [1:0] {MODE_STOP, MODE_UP, MODE_CONT, MODE_UPDOWN} count_mode_e;
  typedef enum logic [1:0] {CAP_IN_A, CAP_IN_B, CAP_IN_GND, CAP_IN_VCC} cap_in_e;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} cap_edge_e;
  typedef enum logic [2:0] {
    OUT_VALUE, OUT_SET, OUT_TOG_RST, OUT_SET_RST,
    OUT_TOG, OUT_RST, OUT_TOG_SET, OUT_RST_SET
  } out_mode_e;

  typedef struct packed {
    logic             capture;
    cap_edge_e        edge_sel;
    cap_in_e          in_sel;
    out_mode_e        out_mode;
    logic             out_value;
    logic [CNT_W-1:0] compare;
  } chan_cfg_s;

  typedef struct packed {
    logic             out;
    logic             irq;
    logic [CNT_W-1:0] capture;
  } chan_stat_s;

endpackage

// ==== tb/pin_model.sv ====
/*
  Pin-side partner of the general timer: pin clocks and capture input pins.
  Assumes the bench calls its tasks; every pin changes just after a rising mclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_model import tmr_pkg::*; (
  input  wire logic              mclk,
  output var  logic              ext_clk,
  output var  logic              alt_clk,
  output var  logic              aux_clk,
  output var  logic [NUM_CH-1:0] cap_a,
  output var  logic [NUM_CH-1:0] cap_b
);
  // Alternate clock idles high since the timer counts on its falling edge
  initial begin
    ext_clk = 1'b0;
    alt_clk = 1'b1;
    aux_clk = 1'b0;
    cap_a   = '0;
    cap_b   = '0;
  end

  // Each level lasts 3 mclk so the two-flop synchronisers never miss it
  task automatic clk_pulses(input clk_src_e src, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge mclk);
      case (src)
        CLK_EXT: ext_clk <= ~ext_clk;
        CLK_AUX: aux_clk <= ~aux_clk;
        default: alt_clk <= ~alt_clk;
      endcase
      repeat (2) @(posedge mclk);
    end
  endtask

  task automatic cap_pulse(input int ch, input bit use_b);
    @(posedge mclk);
    if (use_b) cap_b[ch] <= 1'b1;
    else cap_a[ch] <= 1'b1;
    repeat (4) @(posedge mclk);
    cap_a <= '0;
    cap_b <= '0;
  endtask
endmodule // pin_model
`default_nettype wire

// ==== tb/tb_general_timer.sv ====
/*
  Self-checking bench for the general timer and its conversion-trigger selector.
  Assumes pin_model on the pin side; basic-timer outputs and software start come from here.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_general_timer import tmr_pkg::*;;
  localparam int TIMEOUT = 20000;

  logic                        mclk = 1'b0;
  logic                        rst_b = 1'b0;
  count_mode_e                 count_mode = MODE_STOP;
  clk_src_e                    clk_sel = CLK_SUBSYS;
  wire logic                   ext_clk;
  wire logic                   alt_clk;
  wire logic                   aux_clk;
  wire logic [NUM_CH-1:0]      cap_a;
  wire logic [NUM_CH-1:0]      cap_b;
  chan_cfg_s [NUM_CH-1:0]      cfg = '0;
  logic [2:0]                  trig_sel = 3'h0;
  logic                        sw_start = 1'b0;
  logic [NUM_BT-1:0]           bt_out = 4'h0;
  logic [CNT_W-1:0]            counter_value;
  chan_stat_s [NUM_CH-1:0]     chan_status;
  logic                        overflow_irq;
  logic                        conv_trigger;
  int                          error_cnt = 0;
  int                          check_count = 0;
  int                          cycle_cnt = 0;

  always #20 mclk = ~mclk;

  general_timer i_dut (
    .mclk(mclk), .rst_b(rst_b), .count_mode(count_mode), .clk_sel(clk_sel),
    .external_timer_clock(ext_clk), .alternate_timer_clock(alt_clk), .aux_clock(aux_clk),
    .capture_in_a(cap_a), .capture_in_b(cap_b), .chan_cfg(cfg),
    .conv_trigger_select(trig_sel), .software_conv_start(sw_start),
    .basic_timer_ch1_out(bt_out), .counter_value(counter_value),
    .chan_status(chan_status), .overflow_irq(overflow_irq), .conv_trigger(conv_trigger)
  );

  pin_model i_pins (
    .mclk(mclk), .ext_clk(ext_clk), .alt_clk(alt_clk), .aux_clk(aux_clk),
    .cap_a(cap_a), .cap_b(cap_b)
  );

  // ----------------------------------------
  // Checks and verdict
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Guards against a hang in any bounded wait that slipped
  always @(posedge mclk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == TIMEOUT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic apply_reset();
    @(posedge mclk);
    rst_b      <= 1'b0;
    cfg        <= '0;
    count_mode <= MODE_STOP;
    clk_sel    <= CLK_SUBSYS;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic wait_ovf();
    for (int i = 0; i < 40 && overflow_irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic expect_capture(input int ch, input logic [15:0] exp);
    logic seen;
    seen = 1'b0;
    repeat (12) begin
      @(posedge mclk);
      #1;
      if (chan_status[ch].irq === 1'b1) seen = 1'b1;
    end
    chk_bit(seen, 1'b1);
    chk_word(chan_status[ch].capture, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_period();
    int               seen [NUM_CH];
    logic [NUM_CH-1:0] out_ref;
    int               gap;
    apply_reset();
    for (int k = 0; k < NUM_CH; k++) begin
      cfg[k].compare  <= (k == 0) ? 16'h0009 : 16'(k);
      cfg[k].out_mode <= OUT_TOG;
      seen[k] = 0;
    end
    count_mode <= MODE_UP;
    #1;
    chk_word(counter_value, CNT_RST);
    wait_ovf();
    chk_word(counter_value, CNT_RST);
    for (int k = 0; k < NUM_CH; k++) out_ref[k] = chan_status[k].out;
    gap = 0;
    do begin
      @(posedge mclk);
      #1;
      gap++;
      for (int k = 0; k < NUM_CH; k++) seen[k] += int'(chan_status[k].irq === 1'b1);
    end while (overflow_irq !== 1'b1 && gap < 40);
    chk_word(16'(gap), 16'h000a);
    for (int k = 0; k < NUM_CH; k++) begin
      chk_word(16'(seen[k]), 16'h0001);
      chk_bit(chan_status[k].out, ~out_ref[k]);
    end
  endtask

  task automatic test_capture();
    logic [15:0] held;
    apply_reset();
    for (int k = 1; k < 5; k++) begin
      cfg[k].capture  <= 1'b1;
      cfg[k].edge_sel <= (k == 2) ? EDGE_FALL : (k == 3) ? EDGE_BOTH : EDGE_RISE;
    end
    cfg[1].in_sel <= CAP_IN_B;
    cfg[4].in_sel <= CAP_IN_GND;
    count_mode    <= MODE_CONT;
    repeat (20) @(posedge mclk);
    count_mode <= MODE_STOP;
    repeat (3) @(posedge mclk);
    #1;
    held = counter_value;
    // Twenty subsystem-clock ticks from zero before the stop
    chk_word(held, 16'h0014);
    // Counter frozen, so the captured count is known exactly; the request
    // pulse lasts one cycle, so it is watched while the pin still moves
    fork
      i_pins.cap_pulse(3, 1'b0);
      expect_capture(3, held);
    join
    fork
      i_pins.cap_pulse(1, 1'b1);
      expect_capture(1, held);
    join
    fork
      i_pins.cap_pulse(2, 1'b0);
      expect_capture(2, held);
    join
    @(posedge mclk);
    cfg[4].in_sel <= CAP_IN_VCC;
    expect_capture(4, held);
  endtask

  task automatic test_pin_clocks();
    clk_src_e    srcs [3] = '{CLK_EXT, CLK_AUX, CLK_ALT};
    logic [15:0] start;
    for (int s = 0; s < 3; s++) begin
      apply_reset();
      count_mode <= MODE_CONT;
      clk_sel    <= srcs[s];
      repeat (5) @(posedge mclk);
      #1;
      start = counter_value;
      chk_word(start, CNT_RST);
      i_pins.clk_pulses(srcs[s], 5);
      repeat (6) @(posedge mclk);
      #1;
      chk_word(counter_value, 16'h0005);
    end
  endtask

  // Period 9 in up mode with one output mode per channel, then period 3 in up/down mode
  task automatic test_modes();
    out_mode_e         modes [NUM_CH] = '{OUT_VALUE, OUT_SET_RST, OUT_RST_SET, OUT_TOG_RST,
                                          OUT_TOG_SET, OUT_SET, OUT_RST};
    logic [NUM_CH-1:0] outs;
    int                gap;
    apply_reset();
    for (int k = 0; k < NUM_CH; k++) begin
      cfg[k].compare  <= (k == 0) ? 16'h0009 : 16'(k);
      cfg[k].out_mode <= modes[k];
    end
    count_mode <= MODE_UP;
    wait_ovf();
    for (int k = 0; k < NUM_CH; k++) outs[k] = chan_status[k].out;
    chk_word(16'(outs), 16'h0034);
    // Channel six matches on the seventh tick after the wrap
    repeat (7) @(posedge mclk);
    #1;
    for (int k = 0; k < NUM_CH; k++) outs[k] = chan_status[k].out;
    chk_word(16'(outs), 16'h002a);
    apply_reset();
    cfg[0].compare <= 16'h0003;
    count_mode     <= MODE_UPDOWN;
    wait_ovf();
    chk_word(counter_value, CNT_RST);
    gap = 0;
    do begin
      @(posedge mclk);
      #1;
      gap++;
    end while (overflow_irq !== 1'b1 && gap < 40);
    // Three steps up and three down between requests
    chk_word(16'(gap), 16'h0006);
  endtask

  // Source order follows the selector code: sw, bt0, ch0, ch1, bt1, bt2, bt3
  task automatic set_sources(input logic [2:0] sel, input logic [6:0] v);
    @(posedge mclk);
    trig_sel          <= sel;
    sw_start          <= v[0];
    bt_out            <= {v[6:4], v[1]};
    cfg[0].out_value  <= v[2];
    cfg[1].out_value  <= v[3];
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic test_trigger();
    apply_reset();
    for (int c = 0; c < 8; c++) begin
      set_sources(3'(c), 7'h01 << c);
      chk_bit(conv_trigger, c != 7);
      set_sources(3'(c), ~(7'h01 << c));
      chk_bit(conv_trigger, 1'b0);
    end
  endtask

  initial begin
    test_period();
    test_capture();
    test_pin_clocks();
    test_modes();
    test_trigger();
    give_verdict();
  end
endmodule // tb_general_timer
`default_nettype wire
